// file: src/usbsc_pkg.sv
// Shared constants of the USB PHY suspend control block: offsets, field positions, resets.
// Assumes a byte-addressed register port with 32-bit aligned words.
package usbsc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_PWR_SIG = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_PHY_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h4C;

  // Power signalling fields.
  localparam int unsigned PWR_VALID_BIT = 8;
  localparam int unsigned PWR_DATA_LSB = 0;
  localparam int unsigned PWR_DATA_W = 8;

  // PHY control fields.
  localparam int unsigned CTL_PD_DIS_BIT = 18;
  localparam int unsigned CTL_RST_CAUSE_BIT = 13;
  localparam int unsigned CTL_RES_CAUSE_BIT = 12;
  localparam int unsigned CTL_DEB_LSB = 8;
  localparam int unsigned CTL_DEB_W = 4;
  localparam int unsigned CTL_HW_RES_BIT = 7;
  localparam int unsigned CTL_CFG_LSB = 4;
  localparam int unsigned CTL_CFG_W = 3;

  // Interrupt status layout.
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_RST_BIT = 0;
  localparam int unsigned IRQ_RES_BIT = 1;
  localparam int unsigned IRQ_LS_BIT = 2;

  // Values after reset.
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

  // Line state codes and synchroniser depth.
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_K = 2'h2;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned DEB_CNT_W = 16;

  typedef enum logic [1:0] {USBSC_RUN, USBSC_SUSP} usbsc_state_t;

endpackage : usbsc_pkg

// file: src/usbsc_debounce.sv
// Line state debounce filter with a programmable power-of-two hold time.
// Assumes its input is already synchronised to clk_i.
module usbsc_debounce
  import usbsc_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control.
  input wire logic [CTL_DEB_W-1:0] log2_i,
  // Data.
  input wire logic [WIDTH-1:0] raw_i,
  output logic [WIDTH-1:0] filt_o
);

  logic [WIDTH-1:0] prev_q;
  logic [DEB_CNT_W-1:0] cnt_q;
  logic [DEB_CNT_W-1:0] limit;

  assign limit = DEB_CNT_W'((DEB_CNT_W'(1) << log2_i) - DEB_CNT_W'(1));

  // Any wobble on the input restarts the count, so only a settled level passes.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_q <= '0;
      cnt_q <= '0;
      filt_o <= '0;
    end else begin
      prev_q <= raw_i;
      if (raw_i != prev_q || raw_i == filt_o) begin
        cnt_q <= '0;
      end else if (cnt_q == limit) begin
        filt_o <= raw_i;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + DEB_CNT_W'(1);
      end
    end
  end

  property p_deb_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
    (filt_o != $past(filt_o)) |-> ($past(cnt_q) == $past(limit));
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("Filter changed early.");

endmodule : usbsc_debounce

// file: src/usbsc_top.sv
// USB PHY suspend control register bank with line state filter and resume handler.
// Assumes a single-cycle register port and a PHY line state arriving asynchronously.
// What this block does
// - Writing one to the pulldown-disable bit turns off the pulldowns of the two ports.
// - An automatic resume caused by SE0 sets the reset-cause bit, cleared only by writing zero.
// - An automatic resume caused by K sets the resume-cause bit, cleared only by writing zero.
// - A line state change propagates only after two to the programmed power clock cycles.
// - With the resume-select bit set the suspend controller resumes on its own, otherwise never.
// - The three PHY configuration pins follow the three-bit control field bit for bit.
//
// The implementer's own choice: strobed register access.
module usbsc_top
  import usbsc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // PHY side.
  input wire logic [1:0] linestate_i,
  input wire logic suspend_i,
  output logic [1:0] linestate_filt_o,
  output logic pulldown_dis_o,
  output logic [CTL_CFG_W-1:0] phy_config_inputs_o,
  output logic resume_o,
  output logic pwr_valid_o,
  output logic [PWR_DATA_W-1:0] pwr_data_o,
  // Interrupt.
  output logic irq_o
);

  logic [1:0] ls_sync_q [SYNC_STAGES];
  logic [1:0] ls_stable_q;
  logic [1:0] ls_filt;
  logic rst_cause_q;
  logic res_cause_q;
  logic [CTL_DEB_W-1:0] deb_log2_q;
  logic hw_res_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_set;
  usbsc_state_t state_q;
  logic wr_ctrl;
  logic wr_pwr;
  logic set_rst;
  logic set_res;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] rd_word;

  assign wr_ctrl = wr_i && (addr_i == OFS_PHY_CTRL);
  assign wr_pwr = wr_i && (addr_i == OFS_PWR_SIG);

  // The line state crosses from the PHY, so it passes three synchroniser flops and a stability flop before use.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        ls_sync_q[i] <= '0;
      end
      ls_stable_q <= '0;
    end else begin
      ls_sync_q[0] <= linestate_i;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        ls_sync_q[i] <= ls_sync_q[i-1];
      end
      if (ls_sync_q[1] == ls_sync_q[2]) begin
        ls_stable_q <= ls_sync_q[2];
      end
    end
  end

  usbsc_debounce #(
    .WIDTH(2)
  ) u_debounce (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .log2_i(deb_log2_q),
    .raw_i(ls_stable_q),
    .filt_o(ls_filt)
  );

  // The filtered state is what software polls when hardware resume is off.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      linestate_filt_o <= '0;
    end else begin
      linestate_filt_o <= ls_filt;
    end
  end

  // Power signalling word.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_valid_o <= RST_WORD[PWR_VALID_BIT];
      pwr_data_o <= RST_WORD[PWR_DATA_LSB +: PWR_DATA_W];
    end else if (wr_pwr) begin
      pwr_valid_o <= wdata_i[PWR_VALID_BIT];
      pwr_data_o <= wdata_i[PWR_DATA_LSB +: PWR_DATA_W];
    end
  end

  // Plain control fields of the PHY control word.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulldown_dis_o <= RST_WORD[CTL_PD_DIS_BIT];
      deb_log2_q <= RST_WORD[CTL_DEB_LSB +: CTL_DEB_W];
      hw_res_q <= RST_WORD[CTL_HW_RES_BIT];
      phy_config_inputs_o <= RST_WORD[CTL_CFG_LSB +: CTL_CFG_W];
    end else if (wr_ctrl) begin
      pulldown_dis_o <= wdata_i[CTL_PD_DIS_BIT];
      deb_log2_q <= wdata_i[CTL_DEB_LSB +: CTL_DEB_W];
      hw_res_q <= wdata_i[CTL_HW_RES_BIT];
      phy_config_inputs_o <= wdata_i[CTL_CFG_LSB +: CTL_CFG_W];
    end
  end

  // Suspend controller; it only acts while hardware resume is selected.
  assign set_rst = (state_q == USBSC_SUSP) && hw_res_q && (ls_filt == LS_SE0);
  assign set_res = (state_q == USBSC_SUSP) && hw_res_q && (ls_filt == LS_K);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= USBSC_RUN;
      resume_o <= 1'b0;
    end else begin
      resume_o <= 1'b0;
      unique case (state_q)
        USBSC_RUN: begin
          if (suspend_i && hw_res_q) begin
            state_q <= USBSC_SUSP;
          end
        end
        USBSC_SUSP: begin
          if (!hw_res_q) begin
            state_q <= USBSC_RUN;
          end else if (set_rst || set_res) begin
            state_q <= USBSC_RUN;
            resume_o <= 1'b1;
          end
        end
        // A flipped state bit must not strand the controller, so it falls back to run.
        default: begin
          state_q <= USBSC_RUN;
        end
      endcase
    end
  end

  // Cause bits: software may only clear them, and a new cause beats a clear.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_cause_q <= RST_WORD[CTL_RST_CAUSE_BIT];
      res_cause_q <= RST_WORD[CTL_RES_CAUSE_BIT];
    end else begin
      if (set_rst) begin
        rst_cause_q <= 1'b1;
      end else if (wr_ctrl && !wdata_i[CTL_RST_CAUSE_BIT]) begin
        rst_cause_q <= 1'b0;
      end
      if (set_res) begin
        res_cause_q <= 1'b1;
      end else if (wr_ctrl && !wdata_i[CTL_RES_CAUSE_BIT]) begin
        res_cause_q <= 1'b0;
      end
    end
  end

  // Interrupt status, enable and level output.
  assign irq_set = {ls_filt != linestate_filt_o, set_res, set_rst};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_q <= RST_IRQ;
    end else if (wr_i && addr_i == OFS_IRQ_CLEAR) begin
      irq_stat_q <= (irq_stat_q & ~wdata_i[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_en_q <= RST_IRQ;
    end else if (wr_i && addr_i == OFS_IRQ_ENABLE) begin
      irq_en_q <= wdata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // Read side; reserved bits and unmapped offsets read zero.
  always_comb begin
    ctrl_word = RST_WORD;
    ctrl_word[CTL_PD_DIS_BIT] = pulldown_dis_o;
    ctrl_word[CTL_RST_CAUSE_BIT] = rst_cause_q;
    ctrl_word[CTL_RES_CAUSE_BIT] = res_cause_q;
    ctrl_word[CTL_DEB_LSB +: CTL_DEB_W] = deb_log2_q;
    ctrl_word[CTL_HW_RES_BIT] = hw_res_q;
    ctrl_word[CTL_CFG_LSB +: CTL_CFG_W] = phy_config_inputs_o;
  end

  always_comb begin
    rd_word = RST_WORD;
    unique case (addr_i)
      OFS_PWR_SIG: begin
        rd_word[PWR_VALID_BIT] = pwr_valid_o;
        rd_word[PWR_DATA_LSB +: PWR_DATA_W] = pwr_data_o;
      end
      OFS_PHY_CTRL: rd_word = ctrl_word;
      OFS_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_stat_q;
      OFS_IRQ_ENABLE: rd_word[IRQ_W-1:0] = irq_en_q;
      default: rd_word = RST_WORD;
    endcase
  end

  // Read data stand for exactly one cycle so stale words never linger on the port.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= RST_WORD;
    end else if (rd_i) begin
      rdata_o <= rd_word;
    end else begin
      rdata_o <= RST_WORD;
    end
  end

  sequence s_susp_se0;
    (state_q == USBSC_SUSP) && hw_res_q && (ls_filt == LS_SE0);
  endsequence

  sequence s_susp_k;
    (state_q == USBSC_SUSP) && hw_res_q && (ls_filt == LS_K);
  endsequence

  property p_pulldown;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> (pulldown_dis_o == $past(wdata_i[CTL_PD_DIS_BIT]));
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("Pulldown control wrong.");

  property p_rst_cause;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_susp_se0 |=> rst_cause_q && resume_o && (state_q == USBSC_RUN);
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("Reset cause not set.");

  property p_res_cause;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_susp_k |=> res_cause_q && resume_o && (state_q == USBSC_RUN);
  endproperty
  a_res_cause: assert property (p_res_cause) else $error("Resume cause not set.");

  property p_cause_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
    rst_cause_q && !(wr_ctrl && !wdata_i[CTL_RST_CAUSE_BIT]) |=> rst_cause_q;
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("Reset cause lost.");

  property p_no_auto;
    @(posedge clk_i) disable iff (!arst_n_i)
    !hw_res_q |=> !resume_o ##1 (state_q == USBSC_RUN || hw_res_q);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("Resume without selection.");

  property p_cfg;
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl |=> (phy_config_inputs_o == $past(wdata_i[CTL_CFG_LSB +: CTL_CFG_W]));
  endproperty
  a_cfg: assert property (p_cfg) else $error("Config pins wrong.");

  property p_reserved;
    @(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == OFS_PHY_CTRL) |=> (rdata_o[31:19] == 13'h0000)
      && (rdata_o[17:14] == 4'h0) && (rdata_o[3:0] == 4'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits not zero.");

  property p_irq;
    @(posedge clk_i) disable iff (!arst_n_i)
    ((irq_stat_q & irq_en_q) != RST_IRQ) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised.");

  property p_resume_pulse;
    @(posedge clk_i) disable iff (!arst_n_i)
    resume_o |=> !resume_o;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("Resume pulse too long.");

  property p_set_wins;
    @(posedge clk_i) disable iff (!arst_n_i)
    s_susp_k |=> irq_stat_q[IRQ_RES_BIT] && res_cause_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Resume cause event lost.");

endmodule : usbsc_top

// file: verification/usbsc_phy_model.sv
// Behavioural model of the PHY that stands behind the suspend control block.
// Assumes the bench commands the bus state; the PHY presents it one clock later.
module usbsc_phy_model (
  // Clock.
  input wire logic clk_i,
  // Pins from the block.
  input wire logic pulldown_dis_i,
  input wire logic [2:0] cfg_i,
  // Bus state commanded by the bench.
  input wire logic [1:0] ls_cmd_i,
  // Towards the block and the bench.
  output logic [1:0] linestate_o,
  output logic pd_on_o,
  output logic [2:0] cfg_seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line state changes after an edge, so the block sees it as a truly late input.
  always_ff @(posedge clk_i) begin
    linestate_o <= ls_cmd_i;
  end
  assign pd_on_o = ~pulldown_dis_i;
  assign cfg_seen_o = cfg_i;
endmodule : usbsc_phy_model

// file: verification/testbench.sv
// Self-checking bench for the suspend control register bank.
// Assumes the PHY model is compiled first and the package is available.
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  import usbsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] LS_J = 2'h1;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic suspend_i = 1'b0;
  logic [1:0] ls_cmd = 2'h1;
  logic [31:0] rdata_o;
  logic [1:0] linestate_i, linestate_filt_o;
  logic pulldown_dis_o, resume_o, pwr_valid_o, irq_o, pd_on;
  logic [2:0] phy_config_inputs_o, cfg_seen;
  logic [7:0] pwr_data_o;
  int num_errors = 0;
  int checks_done = 0;
  bit seen;
  int n;
  usbsc_top usbsc_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .linestate_i(linestate_i), .suspend_i(suspend_i), .linestate_filt_o(linestate_filt_o),
    .pulldown_dis_o(pulldown_dis_o), .phy_config_inputs_o(phy_config_inputs_o),
    .resume_o(resume_o), .pwr_valid_o(pwr_valid_o), .pwr_data_o(pwr_data_o), .irq_o(irq_o));
  usbsc_phy_model usbsc_phy_model_inst (.clk_i(clk_i), .pulldown_dis_i(pulldown_dis_o),
    .cfg_i(phy_config_inputs_o), .ls_cmd_i(ls_cmd), .linestate_o(linestate_i),
    .pd_on_o(pd_on), .cfg_seen_o(cfg_seen));
  always #10 clk_i = ~clk_i;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(nm, ex, rdata_o)
  endtask : rchk
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : cyc
  // Watches every cycle because the resume pulse stands for one cycle only.
  task automatic wait_res(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk_i);
      #1;
      if (resume_o === 1'b1) seen = 1'b1;
    end
  endtask : wait_res
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200_000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    cyc(60);
    `CHK("pd_out", 1'b0, pulldown_dis_o)
    rchk("pwr_rst", OFS_PWR_SIG, 32'h0);
    rchk("ctl_rst", OFS_PHY_CTRL, 32'h0);
    rchk("ien_rst", OFS_IRQ_ENABLE, 32'h0);
    wr(OFS_PWR_SIG, 32'hFFFF_FFFF);
    rchk("pwr_rw", OFS_PWR_SIG, 32'h0000_01FF);
    `CHK("pwr_pins", 9'h1FF, {pwr_valid_o, pwr_data_o})
    wr(OFS_PHY_CTRL, 32'hFFFF_FF7F);
    rchk("ctl_rw", OFS_PHY_CTRL, 32'h0004_0F70);
    `CHK("pd_off", 1'b0, pd_on)
    wr(8'h50, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h50, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_PHY_CTRL, 32'(c) << CTL_CFG_LSB);
      cyc(2);
      `CHK("cfg_pins", 3'(c), cfg_seen)
      `CHK("pd_on", 1'b1, pd_on)
    end
    // A glitch one cycle short of the hold time must not pass; a steady change must.
    for (int k = 2; k < 4; k++) begin
      wr(OFS_PHY_CTRL, 32'(k) << CTL_DEB_LSB);
      ls_cmd <= LS_J;
      cyc(40);
      ls_cmd <= LS_K;
      cyc((1 << k) - 1);
      ls_cmd <= LS_J;
      cyc(40);
      `CHK("deb_glitch", LS_J, linestate_filt_o)
      ls_cmd <= LS_K;
      n = 0;
      while (linestate_filt_o !== LS_K && n < 80) begin
        cyc(1);
        n++;
      end
      `CHK("deb_min", 1'b1, n >= (1 << k) + 5)
      `CHK("deb_max", 1'b1, n <= (1 << k) + 9)
    end
    ls_cmd <= LS_J;
    wr(OFS_PHY_CTRL, 32'h0);
    cyc(20);
    @(posedge clk_i) suspend_i <= 1'b1;
    ls_cmd <= LS_K;
    wait_res(40);
    `CHK("no_auto", 1'b0, seen)
    `CHK("poll_k", LS_K, linestate_filt_o)
    rchk("no_cause", OFS_PHY_CTRL, 32'h0);
    @(posedge clk_i) suspend_i <= 1'b0;
    ls_cmd <= LS_J;
    wr(OFS_IRQ_ENABLE, 32'h3);
    wr(OFS_IRQ_CLEAR, 32'h7);
    wr(OFS_PHY_CTRL, 32'h80);
    cyc(20);
    @(posedge clk_i) suspend_i <= 1'b1;
    cyc(2);
    ls_cmd <= LS_K;
    wait_res(30);
    @(posedge clk_i) suspend_i <= 1'b0;
    `CHK("k_resume", 1'b1, seen)
    rchk("k_cause", OFS_PHY_CTRL, 32'h1080);
    rchk("irq_stat", OFS_IRQ_STATUS, 32'h0000_0006);
    rchk("clr_reads", OFS_IRQ_CLEAR, 32'h0);
    cyc(3);
    `CHK("irq_set", 1'b1, irq_o)
    wr(OFS_IRQ_ENABLE, 32'h0);
    cyc(3);
    `CHK("irq_mask", 1'b0, irq_o)
    wr(OFS_IRQ_ENABLE, 32'h3);
    wr(OFS_IRQ_CLEAR, 32'h3);
    cyc(3);
    `CHK("irq_clr", 1'b0, irq_o)
    ls_cmd <= LS_J;
    wr(OFS_PHY_CTRL, 32'h80);
    rchk("k_clear", OFS_PHY_CTRL, 32'h80);
    cyc(20);
    @(posedge clk_i) suspend_i <= 1'b1;
    cyc(2);
    ls_cmd <= LS_SE0;
    wait_res(30);
    @(posedge clk_i) suspend_i <= 1'b0;
    `CHK("se0_resume", 1'b1, seen)
    rchk("se0_cause", OFS_PHY_CTRL, 32'h2080);
    wr(OFS_PHY_CTRL, 32'h0000_3080);
    rchk("se0_hold", OFS_PHY_CTRL, 32'h2080);
    wr(OFS_PHY_CTRL, 32'h80);
    rchk("se0_clear", OFS_PHY_CTRL, 32'h80);
    tally_and_finish();
  end
endmodule : testbench
